/* File: common/modem_sup_pkg.sv */
// Constants shared by the modem handshake supervisor and its tick divider.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package modem_sup_pkg;
  // Clock and supervision timing
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DSR_LOSS_MS   = 10;
  localparam int unsigned PRECHECK_MS   = 20;
  localparam int unsigned CTS_FAIL_S    = 30;
  localparam int unsigned DSR_LOSS_TICKS = DSR_LOSS_MS / TICK_MS;
  localparam int unsigned PRE_TICKS      = PRECHECK_MS / TICK_MS;
  localparam int unsigned CTS_TICKS      = CTS_FAIL_S * 1000 / TICK_MS;
  localparam int unsigned TIMER_W        = 12;

  // Register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_IRQ_ST = 5'h08;
  localparam logic [4:0] OFF_IRQ_MK = 5'h0C;
  localparam logic [4:0] OFF_RESP   = 5'h10;

  // Control register fields
  localparam int unsigned CTRL_START  = 0;
  localparam int unsigned CTRL_DTR    = 1;
  localparam int unsigned CTRL_AUTOAN = 2;
  localparam int unsigned CTRL_RLOAD  = 3;
  localparam int unsigned CTRL_BOOT   = 4;
  localparam int unsigned CTRL_W      = 5;

  // Interrupt status / mask fields
  localparam int unsigned IRQ_DSR_LOSS = 0;
  localparam int unsigned IRQ_CTS_FAIL = 1;
  localparam int unsigned IRQ_W        = 2;

  // Response register: code byte plus valid flag
  localparam int unsigned RESP_VALID_BIT = 8;
  localparam logic [7:0] CODE_DISCONNECT = 8'h01;
  localparam logic [7:0] CODE_CTS_FAIL   = 8'h02;

  // AXI responses
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Supervisor states, one-hot
  typedef enum logic [8:0] {
    ST_OFF      = 9'h001,
    ST_WAIT_DSR = 9'h002,
    ST_PRECHECK = 9'h004,
    ST_WAIT_CTS = 9'h008,
    ST_SEND     = 9'h010,
    ST_RESYNC   = 9'h020,
    ST_IDLE_TR  = 9'h040,
    ST_DROP_DTR = 9'h080,
    ST_QUEUE    = 9'h100
  } sup_state_e;
endpackage
`default_nettype wire

/* File: sim/hs_checker.sv */
// Checker for the modem handshake supervisor, bound to its top module.
// Assumes one clock domain and a short tick length set by the bench.
`default_nettype none
module hs_checker
  import modem_sup_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        dsr,
  input wire logic        cts,
  input wire logic        rts,
  input wire logic        dtr,
  input wire logic        tx_enable,
  input wire logic        resync_pulse,
  input wire logic        idle_pulse
);
  logic [31:0] dsr_lo_q;
  logic [31:0] cts_lo_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles spent with RTS up while DSR or CTS is down
  always_ff @(posedge clk_sys) begin
    dsr_lo_q <= (!rst_n || !rts || dsr) ? 32'h0 : dsr_lo_q + 32'h1;
    cts_lo_q <= (!rst_n || !rts || cts) ? 32'h0 : cts_lo_q + 32'h1;
  end
  AST_TX_DSR: assert property (tx_enable |-> dsr)
    else $error("transmit enabled without dsr");
  AST_TX_CTS: assert property (tx_enable |-> cts && dtr)
    else $error("transmit enabled without cts or dtr");
  AST_RTS_DTR: assert property (rts |-> dtr)
    else $error("rts up without dtr");
  AST_SEQ: assert property (resync_pulse |=> idle_pulse && !resync_pulse)
    else $error("idle does not follow resync");
  AST_RTS_LOW: assert property (resync_pulse |=> !rts [*3])
    else $error("rts up during fault recovery");
  AST_DTR_DROP: assert property (idle_pulse |-> ##2 !dtr)
    else $error("dtr not dropped after idle");
  AST_DSR_LOSS: assert property (dsr_lo_q <= 2 * TICK_LEN + 3)
    else $error("dsr loss not acted on");
  AST_CTS_FAIL: assert property (cts_lo_q <= (CTS_TICKS + 1) * TICK_LEN + 4)
    else $error("cts failure not acted on");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule
bind modem_handshake_supervisor hs_checker #(.TICK_LEN(TICK_LEN)) chk_u (
  .clk_sys      (clk_sys),
  .rst_n        (rst_n),
  .s_axi_bvalid (s_axi_bvalid),
  .s_axi_bready (s_axi_bready),
  .s_axi_bresp  (s_axi_bresp),
  .s_axi_rvalid (s_axi_rvalid),
  .s_axi_rready (s_axi_rready),
  .s_axi_rdata  (s_axi_rdata),
  .dsr          (dsr),
  .cts          (cts),
  .rts          (rts),
  .dtr          (dtr),
  .tx_enable    (tx_enable),
  .resync_pulse (resync_pulse),
  .idle_pulse   (idle_pulse)
);
`default_nettype wire

/* File: sim/modem_handshake_supervisor_tb.sv */
// Self-checking bench: AXI4-Lite register tasks and modem scenarios.
// Assumes the behavioural modem model and a four-cycle tick.
`default_nettype none
module modem_handshake_supervisor_tb
  import modem_sup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic        clk_sys = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        mode_def_valid = 1'h0, mode_def_half_duplex = 1'h0, tx_request = 1'h0;
  logic        dsr_on = 1'h0;
  logic [1:0]  cts_mode = 2'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rts, dtr, tx_enable, rx_enable, resync_pulse, idle_pulse, irq, dsr, cts;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          fails = 0, checks_done = 0;
  modem_handshake_supervisor #(
    .TICK_LEN (TK)
  ) dut_u (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .dsr                  (dsr),
    .cts                  (cts),
    .rts                  (rts),
    .dtr                  (dtr),
    .mode_def_valid       (mode_def_valid),
    .mode_def_half_duplex (mode_def_half_duplex),
    .tx_request           (tx_request),
    .tx_enable            (tx_enable),
    .rx_enable            (rx_enable),
    .resync_pulse         (resync_pulse),
    .idle_pulse           (idle_pulse),
    .irq                  (irq)
  );
  modem_model mdm_u (
    .clk_sys  (clk_sys),
    .rts      (rts),
    .dsr_on   (dsr_on),
    .cts_mode (cts_mode),
    .dsr      (dsr),
    .cts      (cts)
  );
  // Free-running system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk1(input string nm, input logic seen, input logic exp);
    check(nm, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic guard(input int n, input int lim);
    if (n > lim) begin
      fails++;
      $display("CHECK FAILED wait expected done seen timeout");
      wrap_up();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic tdone(input int t);
    $display("test %0d finished", t);
  endtask
  // One write: address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      guard(n, 100);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      // Ready comes a cycle late so the response has to wait for it
      if (s_axi_bvalid === 1'h1 && s_axi_bready !== 1'h1) s_axi_bready <= 1'h1;
    end while (s_axi_bvalid !== 1'h1 || s_axi_bready !== 1'h1);
    s_axi_bready <= 1'h0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // One read, data masked then compared
  task automatic rd(input logic [4:0] a, input logic [1:0] er, input logic [31:0] m,
                    input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
      guard(n, 100);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      // Ready comes a cycle late so the read data has to stand
      if (s_axi_rvalid === 1'h1 && s_axi_rready !== 1'h1) s_axi_rready <= 1'h1;
    end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
    s_axi_rready <= 1'h0;
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    check("rdata", s_axi_rdata & m, ex);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return tx_enable === 1'h1;
      1: return resync_pulse === 1'h1;
      default: return rts === 1'h1;
    endcase
  endfunction
  task automatic wait_hi(input int s, input int lim);
    int n;
    n = 0;
    while (!pick(s)) begin
      @(posedge clk_sys);
      n++;
      guard(n, lim);
    end
  endtask
  // Main sequence
  initial begin
    cyc(16);
    rst_n <= 1'h1;
    rd(OFF_CTRL, AXI_OKAY, 32'hFFFFFFFF, 32'h0);
    rd(OFF_STATUS, AXI_OKAY, 32'h1FFFF, 32'h00100);
    rd(5'h14, AXI_SLVERR, 32'h0, 32'h0);
    wr(OFF_STATUS, 32'h1, AXI_SLVERR);
    wr(OFF_CTRL, 32'h23, AXI_OKAY);
    rd(OFF_STATUS, AXI_OKAY, 32'h20, 32'h0);
    tdone(1);
    mode_def_half_duplex <= 1'h1;
    mode_def_valid <= 1'h1;
    tx_request <= 1'h1;
    @(posedge clk_sys);
    mode_def_valid <= 1'h0;
    cyc(50 * TK);
    chk1("rts", rts, 1'h0);
    chk1("tx_enable", tx_enable, 1'h0);
    rd(OFF_STATUS, AXI_OKAY, 32'h1FF28, 32'h00228);
    tdone(2);
    dsr_on <= 1'h1;
    wait_hi(0, 100);
    chk1("cts", cts, 1'h1);
    chk1("rx_enable", rx_enable, 1'h0);
    tdone(3);
    wr(OFF_IRQ_MK, 32'h3, AXI_OKAY);
    dsr_on <= 1'h0;
    cyc(TK + 2);
    chk1("rts", rts, 1'h1);
    wait_hi(1, 4 * TK + 10);
    cyc(6);
    chk1("dtr", dtr, 1'h0);
    chk1("irq", irq, 1'h1);
    rd(OFF_RESP, AXI_OKAY, 32'h1FF, {23'h0, 1'h1, CODE_DISCONNECT});
    rd(OFF_IRQ_ST, AXI_OKAY, 32'h3, 32'h1);
    rd(OFF_IRQ_ST, AXI_OKAY, 32'h3, 32'h0);
    cyc(2);
    chk1("irq", irq, 1'h0);
    tdone(4);
    cts_mode <= 2'h1;
    mode_def_half_duplex <= 1'h0;
    mode_def_valid <= 1'h1;
    dsr_on <= 1'h1;
    @(posedge clk_sys);
    mode_def_valid <= 1'h0;
    cyc(4);
    wr(OFF_CTRL, 32'h3, AXI_OKAY);
    chk1("rts", rts, 1'h0);
    chk1("dtr", dtr, 1'h1);
    wait_hi(2, 4 * TK);
    wait_hi(0, 10);
    chk1("rx_enable", rx_enable, 1'h1);
    tdone(5);
    wr(OFF_IRQ_MK, 32'h1, AXI_OKAY);
    cts_mode <= 2'h2;
    cyc((CTS_TICKS - 2) * TK);
    chk1("rts", rts, 1'h1);
    wait_hi(1, 4 * TK + 10);
    cyc(6);
    chk1("dtr", dtr, 1'h0);
    chk1("irq", irq, 1'h0);
    rd(OFF_RESP, AXI_OKAY, 32'h1FF, {23'h0, 1'h1, CODE_CTS_FAIL});
    wr(OFF_IRQ_MK, 32'h3, AXI_OKAY);
    chk1("irq", irq, 1'h1);
    rd(OFF_IRQ_ST, AXI_OKAY, 32'h3, 32'h2);
    cyc(2);
    chk1("irq", irq, 1'h0);
    tdone(6);
    cts_mode <= 2'h1;
    wr(OFF_CTRL, 32'h7, AXI_OKAY);
    wait_hi(0, 20 * TK);
    dsr_on <= 1'h0;
    wait_hi(1, 4 * TK + 10);
    cyc(6);
    chk1("dtr", dtr, 1'h1);
    tdone(7);
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: sim/modem_model.sv */
// Behavioural modem on the control circuits: drives DSR and CTS.
// Assumes the supervisor's clock; CTS answers RTS LAG + 1 cycles after RTS rises.
`default_nettype none
module modem_model #(
  parameter int LAG = 3
) (
  input  wire logic       clk_sys,
  input  wire logic       rts,
  input  wire logic       dsr_on,
  input  wire logic [1:0] cts_mode,
  output logic            dsr = 1'h0,
  output logic            cts = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag_q = 0;
  // Mode 0 follows RTS, 1 holds CTS on, 2 never answers
  always_ff @(posedge clk_sys) begin
    dsr <= dsr_on;
    if (cts_mode == 2'h1) begin
      cts <= 1'h1;
    end else if (cts_mode == 2'h2 || !rts) begin
      cts <= 1'h0;
      lag_q <= 0;
    end else if (lag_q >= LAG) begin
      cts <= 1'h1;
    end else begin
      lag_q <= lag_q + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/modem_handshake_supervisor.sv */
// Modem handshake supervisor: DSR/RTS/CTS supervision, fault recovery, AXI4-Lite regs.
// Assumes modem inputs already synchronous to clk_sys; single clock domain.
`default_nettype none
// How it works
// - No transmission starts while data-set-ready is low.
// - Once seen, DSR counts as lost only after staying low 10 ms.
// - DSR loss: resync, idle both directions, drop DTR, then queue disconnect.
// - Line start with DSR never seen waits forever, no timeout.
// - CTS already on before RTS: run a 10-20 ms timer awaiting CTS off.
// - CTS still on at timer end is taken as constant; RTS is raised.
// - No transmit until CTS; 30 s without CTS resyncs, idles, drops DTR.
// - CTS failure queues a disconnect carrying the CTS failure code.
// - While RTS is set, CTS is sampled every 10 ms tick.
// - CTS off 30 s with RTS set: queue failure, resync, idle, drop DTR.
// - Receiver is gated off while RTS and half-duplex are both set.
// - After a fault DTR returns alone only with auto-answer, remote load or boot.
// - Half-duplex bit changes only via the mode-definition path, never by the host.
module modem_handshake_supervisor
  import modem_sup_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite slave
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Modem circuits
  input  wire logic        dsr,
  input  wire logic        cts,
  output logic             rts,
  output logic             dtr,
  // Mode-definition command path
  input  wire logic        mode_def_valid,
  input  wire logic        mode_def_half_duplex,
  // Transmitter / receiver side
  input  wire logic        tx_request,
  output logic             tx_enable,
  output logic             rx_enable,
  output logic             resync_pulse,
  output logic             idle_pulse,
  output logic             irq
);
  sup_state_e            state_q;
  logic                  tick;
  logic [CTRL_W-1:0]     ctrl_q;
  logic                  dtr_q;
  logic                  rts_q;
  logic                  half_duplex_q;
  logic                  dsr_seen_q;
  logic                  cts_fault_q;
  logic [TIMER_W-1:0]    dsr_tmr_q;
  logic [TIMER_W-1:0]    pre_tmr_q;
  logic [TIMER_W-1:0]    cts_tmr_q;
  logic [IRQ_W-1:0]      irq_st_q;
  logic [IRQ_W-1:0]      irq_mk_q;
  logic [7:0]            resp_code_q;
  logic                  resp_valid_q;
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [4:0]            awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  dsr_lost;
  logic                  cts_expired;
  logic                  started;
  logic                  auto_dtr;
  logic                  host_dtr_wr;

  tick_divider #(
    .CYCLES (TICK_LEN)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  // Timer step: count on tick, saturate at limit
  function automatic logic [TIMER_W-1:0] step(input logic [TIMER_W-1:0] t,
                                              input logic             en);
    step = (en && t != {TIMER_W{1'b1}}) ? t + {{(TIMER_W-1){1'b0}}, 1'b1} : t;
  endfunction

  // Write decode helper
  function automatic logic wr_hit(input logic [4:0] off);
    wr_hit = wr_fire && (awaddr_q == off);
  endfunction

  // AXI write channel: address and data taken independently
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 5'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == OFF_CTRL || awaddr_q == OFF_IRQ_MK) ? AXI_OKAY
                                                                         : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel: one read at a time, registered data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_CTRL:   s_axi_rdata <= {27'h0, ctrl_q[CTRL_BOOT:CTRL_DTR+1], dtr_q,
                                    ctrl_q[CTRL_START]};
        OFF_STATUS: s_axi_rdata <= {15'h0, state_q, rx_enable, tx_enable, half_duplex_q,
                                    dsr_seen_q, dtr_q, rts_q, cts, dsr};
        OFF_IRQ_ST: s_axi_rdata <= {30'h0, irq_st_q};
        OFF_IRQ_MK: s_axi_rdata <= {30'h0, irq_mk_q};
        OFF_RESP:   s_axi_rdata <= {23'h0, resp_valid_q, resp_code_q};
        default:    s_axi_rresp <= AXI_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control register; the DTR bit is kept apart as dtr_q
  always_comb host_dtr_wr = wr_hit(OFF_CTRL) && wstrb_q[0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q   <= '0;
      irq_mk_q <= '0;
    end else begin
      if (host_dtr_wr) begin
        ctrl_q <= wdata_q[CTRL_W-1:0];
      end
      if (wr_hit(OFF_IRQ_MK) && wstrb_q[0]) begin
        irq_mk_q <= wdata_q[IRQ_W-1:0];
      end
    end
  end

  // Half-duplex bit: written only by the mode-definition path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      half_duplex_q <= 1'b0;
    end else if (mode_def_valid) begin
      half_duplex_q <= mode_def_half_duplex;
    end
  end

  assign started  = ctrl_q[CTRL_START];
  assign auto_dtr = ctrl_q[CTRL_AUTOAN] || ctrl_q[CTRL_RLOAD] || ctrl_q[CTRL_BOOT];

  // DSR supervision: armed once DSR is seen; loss needs two ticks low, so at least 10 ms
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dsr_seen_q <= 1'b0;
      dsr_tmr_q  <= '0;
    end else if (!started || state_q == ST_RESYNC) begin
      dsr_seen_q <= 1'b0;
      dsr_tmr_q  <= '0;
    end else if (dsr) begin
      dsr_seen_q <= 1'b1;
      dsr_tmr_q  <= '0;
    end else begin
      dsr_tmr_q  <= step(dsr_tmr_q, tick && dsr_seen_q);
    end
  end

  assign dsr_lost = dsr_seen_q && !dsr && (dsr_tmr_q > TIMER_W'(DSR_LOSS_TICKS));

  // CTS pre-check timer before RTS, and CTS wait/loss timer while RTS is set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_tmr_q <= '0;
      cts_tmr_q <= '0;
    end else begin
      pre_tmr_q <= (state_q == ST_PRECHECK) ? step(pre_tmr_q, tick) : '0;
      if (!rts_q || (tick && cts)) begin
        cts_tmr_q <= '0;
      end else begin
        cts_tmr_q <= step(cts_tmr_q, tick);
      end
    end
  end

  assign cts_expired = rts_q && (cts_tmr_q >= TIMER_W'(CTS_TICKS));

  // Supervisor sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q     <= ST_OFF;
      rts_q       <= 1'b0;
      cts_fault_q <= 1'b0;
    end else if (!started) begin
      state_q <= ST_OFF;
      rts_q   <= 1'b0;
    end else if (dsr_lost && state_q inside {ST_WAIT_DSR, ST_PRECHECK, ST_WAIT_CTS,
                                              ST_SEND}) begin
      state_q     <= ST_RESYNC;
      rts_q       <= 1'b0;
      cts_fault_q <= 1'b0;
    end else if (cts_expired && state_q inside {ST_WAIT_CTS, ST_SEND}) begin
      state_q     <= ST_RESYNC;
      rts_q       <= 1'b0;
      cts_fault_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          state_q <= ST_WAIT_DSR;
        end
        ST_WAIT_DSR: begin
          if (dsr && dtr_q && tx_request) begin
            if (rts_q) begin
              state_q <= ST_WAIT_CTS;
            end else if (cts) begin
              state_q <= ST_PRECHECK;
            end else begin
              rts_q   <= 1'b1;
              state_q <= ST_WAIT_CTS;
            end
          end else begin
            rts_q <= 1'b0;
          end
        end
        ST_PRECHECK: begin
          if (!cts || pre_tmr_q >= TIMER_W'(PRE_TICKS)) begin
            rts_q   <= 1'b1;
            state_q <= ST_WAIT_CTS;
          end
        end
        ST_WAIT_CTS: begin
          if (!tx_request) begin
            rts_q   <= 1'b0;
            state_q <= ST_WAIT_DSR;
          end else if (cts && dsr) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!tx_request) begin
            rts_q   <= 1'b0;
            state_q <= ST_WAIT_DSR;
          end
        end
        ST_RESYNC:   state_q <= ST_IDLE_TR;
        ST_IDLE_TR:  state_q <= ST_DROP_DTR;
        ST_DROP_DTR: state_q <= ST_QUEUE;
        ST_QUEUE:    state_q <= ST_WAIT_DSR;
        default:     state_q <= ST_OFF;
      endcase
    end
  end

  // DTR: host write-modem control, dropped by a fault, auto-raised on options
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dtr_q <= 1'b0;
    end else if (state_q == ST_DROP_DTR) begin
      dtr_q <= 1'b0;
    end else if (host_dtr_wr) begin
      dtr_q <= wdata_q[CTRL_DTR];
    end else if (state_q == ST_QUEUE && auto_dtr) begin
      dtr_q <= 1'b1;
    end
  end

  // Response slot: CTS failure queues at detection, DSR loss after DTR drop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resp_valid_q <= 1'b0;
      resp_code_q  <= 8'h00;
    end else if (cts_expired && state_q inside {ST_WAIT_CTS, ST_SEND} && !dsr_lost) begin
      resp_valid_q <= 1'b1;
      resp_code_q  <= CODE_CTS_FAIL;
    end else if (state_q == ST_QUEUE && !cts_fault_q) begin
      resp_valid_q <= 1'b1;
      resp_code_q  <= CODE_DISCONNECT;
    end else if (rd_fire && s_axi_araddr == OFF_RESP) begin
      resp_valid_q <= 1'b0;
    end
  end

  // Sticky interrupt status, cleared by a read; a new event wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (rd_fire && s_axi_araddr == OFF_IRQ_ST) begin
          irq_st_q[i] <= 1'b0;
        end
      end
      if (state_q == ST_QUEUE) begin
        irq_st_q[cts_fault_q ? IRQ_CTS_FAIL : IRQ_DSR_LOSS] <= 1'b1;
      end
    end
  end

  // Outputs toward modem and data path
  assign rts          = rts_q;
  assign dtr          = dtr_q;
  assign tx_enable    = (state_q == ST_SEND) && dsr && cts && dtr_q;
  assign rx_enable    = !(rts_q && half_duplex_q) && state_q != ST_OFF;
  assign resync_pulse = (state_q == ST_RESYNC);
  assign idle_pulse   = (state_q == ST_IDLE_TR);
  assign irq          = |(irq_st_q & irq_mk_q);
endmodule
`default_nettype wire

/* File: verilog/tick_divider.sv */
// Divider producing the common supervision tick as a one-cycle enable.
// Assumes one free-running system clock and a synchronous active-low reset.
`default_nettype none
module tick_divider
  import modem_sup_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick
);
  logic [31:0] cnt_q;

  // Count the period and pulse once at its end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire
